// File: include/cfrs_pkg.sv
// Shared constants for the CAN fault recovery supervisor
package cfrs_pkg;

    // Stuck-dominant timeout: plain default, short so a trip stays cheap
    localparam int unsigned CLK_PERIOD_NS     = 8;
    localparam int unsigned DOM_TIMEOUT_US   = 8;
    localparam int unsigned DOM_TIMEOUT_CYC  =
        (DOM_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned DOM_CNT_W        = 20;

    // Reset values
    localparam logic        RST_FAULT        = 1'b0;
    localparam logic        RST_FLAG         = 1'b0;

    // Level written to the re-enable bit that requests recovery
    localparam logic        REENABLE_LEVEL   = 1'b1;

    // Recovery state machine, one-hot
    typedef enum logic [2:0] {
        CFRS_ACTIVE  = 3'h1,
        CFRS_TRIPPED = 3'h2,
        CFRS_WAIT    = 3'h4
    } cfrs_state_e;

endpackage

// File: rtl/cfrs_sync.sv
// Two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
module cfrs_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q;
endmodule

// File: rtl/cfrs_top.sv
// CAN transceiver fault supervision and driver recovery control
`timescale 1ns/1ps
module cfrs_top (
    input  wire logic I_MCLK,
    input  wire logic I_RSTN,
    input  wire logic I_TXD_DOM,
    input  wire logic I_CAN_OVERTEMP,
    input  wire logic I_CANH_OVERCUR,
    input  wire logic I_CANL_OVERCUR,
    input  wire logic I_AUX_SUPPLY_LOW,
    input  wire logic I_AUX_SUPPLY_ON,
    input  wire logic I_MAIN_REG_OVERCUR,
    input  wire logic I_DRIVER_REENABLE_CMD,
    input  wire logic I_FLAG_CLR,
    output logic      O_DRIVER_EN,
    output logic      O_XCVR_ON,
    output logic      O_TXD_DOM_FAIL,
    output logic      O_THERMAL_OVERCURRENT_FLAG
);
    logic [6:0] pins_s;
    logic       txd_dom;
    logic       otemp;
    logic       ocur;
    logic       aux_low;
    logic       aux_on;
    logic       main_oc;

    // Fault inputs come from analog comparators, so they are synchronised
    cfrs_sync #(.W(7)) u_sync (
        .i_clk   (I_MCLK),
        .i_rstn  (I_RSTN),
        .i_async ({I_TXD_DOM, I_CAN_OVERTEMP, I_CANH_OVERCUR,
                   I_CANL_OVERCUR, I_AUX_SUPPLY_LOW, I_AUX_SUPPLY_ON,
                   I_MAIN_REG_OVERCUR}),
        .o_sync  (pins_s)
    );

    assign txd_dom = pins_s[6];
    assign otemp   = pins_s[5];
    assign ocur    = pins_s[4] | pins_s[3];
    assign aux_low = pins_s[2];
    assign aux_on  = pins_s[1];
    assign main_oc = pins_s[0];

    cfrs_pkg::cfrs_state_e      state_q;
    cfrs_pkg::cfrs_state_e      state_d;
    logic [cfrs_pkg::DOM_CNT_W-1:0] cnt_q;
    logic [cfrs_pkg::DOM_CNT_W-1:0] cnt_d;
    logic                       fail_q;
    logic                       fail_d;
    logic                       flag_q;
    logic                       flag_d;
    logic                       drv_q;
    logic                       drv_d;
    logic                       xcvr_q;
    logic                       xcvr_d;
    logic                       timeout;
    logic                       reen;

    localparam logic [cfrs_pkg::DOM_CNT_W-1:0] CNT_LAST =
        cfrs_pkg::DOM_CNT_W'(cfrs_pkg::DOM_TIMEOUT_CYC - 1);

    assign timeout = txd_dom && (cnt_q == CNT_LAST);
    assign reen    = I_DRIVER_REENABLE_CMD == cfrs_pkg::REENABLE_LEVEL;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        fail_d  = fail_q;
        flag_d  = flag_q;
        // A short to the receive output looks identical to a held input
        if (!txd_dom) begin
            cnt_d = '0;
        end else if (cnt_q != CNT_LAST) begin
            cnt_d = cnt_q + 1'b1;
        end
        case (state_q)
            cfrs_pkg::CFRS_ACTIVE: begin
                if (timeout) begin
                    state_d = cfrs_pkg::CFRS_TRIPPED;
                    fail_d  = 1'b1;
                end
            end
            cfrs_pkg::CFRS_TRIPPED: begin
                // Command while still held is dropped, not queued
                if (!txd_dom) begin
                    state_d = cfrs_pkg::CFRS_WAIT;
                end
            end
            cfrs_pkg::CFRS_WAIT: begin
                if (txd_dom) begin
                    state_d = cfrs_pkg::CFRS_TRIPPED;
                end else if (reen) begin
                    state_d = cfrs_pkg::CFRS_ACTIVE;
                    fail_d  = 1'b0;
                end
            end
            default: begin
                state_d = cfrs_pkg::CFRS_TRIPPED;
            end
        endcase
        // Set wins over a clear in the same cycle
        if (otemp || ocur) begin
            flag_d = 1'b1;
        end else if (I_FLAG_CLR) begin
            flag_d = 1'b0;
        end
        // Over-temperature gate is combinational on state: recovers alone
        drv_d  = (state_d == cfrs_pkg::CFRS_ACTIVE) && !otemp;
        xcvr_d = !aux_low && !(main_oc && !aux_on);
        drv_d  = drv_d && xcvr_d;
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RSTN) begin
            state_q <= cfrs_pkg::CFRS_ACTIVE;
            cnt_q   <= '0;
            fail_q  <= cfrs_pkg::RST_FAULT;
            flag_q  <= cfrs_pkg::RST_FLAG;
            drv_q   <= 1'b0;
            xcvr_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            fail_q  <= fail_d;
            flag_q  <= flag_d;
            drv_q   <= drv_d;
            xcvr_q  <= xcvr_d;
        end
    end

    assign O_DRIVER_EN                = drv_q;
    assign O_XCVR_ON                  = xcvr_q;
    assign O_TXD_DOM_FAIL             = fail_q;
    assign O_THERMAL_OVERCURRENT_FLAG = flag_q;

    sequence trip_s;
        state_q == cfrs_pkg::CFRS_TRIPPED;
    endsequence

    timeout_trip_a: assert property (
        @(posedge I_MCLK) disable iff (!I_RSTN)
        (state_q == cfrs_pkg::CFRS_ACTIVE) && timeout
        |=> trip_s ##1 !drv_q)
        else $error("Driver not released after stuck timeout");

    reenable_gate_a: assert property (
        @(posedge I_MCLK) disable iff (!I_RSTN)
        (state_q != cfrs_pkg::CFRS_ACTIVE) && !(reen && !txd_dom)
        |=> state_q != cfrs_pkg::CFRS_ACTIVE)
        else $error("Driver recovered without command");

    no_auto_a: assert property (
        @(posedge I_MCLK) disable iff (!I_RSTN)
        $rose(drv_q) && !$past(otemp, 2) |-> $past(reen)
            || $past(xcvr_q == 1'b0) || $past(drv_q, 3) == 1'b1
            || $past(state_q, 2) == cfrs_pkg::CFRS_ACTIVE)
        else $error("Driver came back with no command");

    flag_set_a: assert property (
        @(posedge I_MCLK) disable iff (!I_RSTN)
        (otemp || ocur) |=> O_THERMAL_OVERCURRENT_FLAG)
        else $error("Thermal over-current flag not set");

    otemp_off_a: assert property (
        @(posedge I_MCLK) disable iff (!I_RSTN)
        otemp |=> !drv_q)
        else $error("Driver on during over-temperature");

    aux_low_a: assert property (
        @(posedge I_MCLK) disable iff (!I_RSTN)
        aux_low |=> !O_XCVR_ON && !O_DRIVER_EN)
        else $error("Transceiver on with aux supply low");

    main_oc_a: assert property (
        @(posedge I_MCLK) disable iff (!I_RSTN)
        main_oc && !aux_on |=> !O_XCVR_ON)
        else $error("Transceiver on during regulator over-current");

    fail_status_a: assert property (
        @(posedge I_MCLK) disable iff (!I_RSTN)
        trip_s |-> O_TXD_DOM_FAIL)
        else $error("Stuck failure not reported");

    drop_cmd_a: assert property (
        @(posedge I_MCLK) disable iff (!I_RSTN)
        (state_q == cfrs_pkg::CFRS_TRIPPED) ##1 (txd_dom [*2])
        |=> state_q != cfrs_pkg::CFRS_ACTIVE)
        else $error("Re-enable retained while stuck");
endmodule

// File: verif/cfrs_host_model.sv
// Host controller model: transmit level and register command levels, each one clock late
`timescale 1ns/1ps
module cfrs_host_model (
    input  wire logic i_clk,
    input  wire logic i_hold_dom,
    input  wire logic i_req_reen,
    input  wire logic i_req_clr,
    output logic      o_txd_dom,
    output logic      o_reenable_cmd,
    output logic      o_flag_clr
);
    // Re-enable is only ever sent when the bench asks, never on its own
    always @(posedge i_clk) begin
        o_txd_dom      <= i_hold_dom;
        o_reenable_cmd <= i_req_reen;
        o_flag_clr     <= i_req_clr;
    end
endmodule

// File: verif/cfrs_top_tb.sv
// Self-checking bench for the CAN fault recovery supervisor
`timescale 1ns/1ps
module cfrs_top_tb;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [5:0]  flt = 6'h00;
    logic        hold = 1'b0;
    logic        reen = 1'b0;
    logic        clr = 1'b0;
    logic        txd;
    logic        rcmd;
    logic        fclr;
    logic        drv;
    logic        xon;
    logic        fail;
    logic        flag;
    logic [19:0] lf = 20'h15cf2;
    logic        fexp = 1'b0;
    logic [5:0]  corner [4] = '{6'h20, 6'h30, 6'h08, 6'h01};
    int          n_fail = 0;
    int          tests_run = 0;

    always #4 clk = ~clk;

    cfrs_host_model cfrs_host_model_i (.i_clk(clk), .i_hold_dom(hold),
        .i_req_reen(reen), .i_req_clr(clr), .o_txd_dom(txd),
        .o_reenable_cmd(rcmd), .o_flag_clr(fclr));
    cfrs_top cfrs_top_i (.I_MCLK(clk), .I_RSTN(rstn), .I_TXD_DOM(txd),
        .I_CAN_OVERTEMP(flt[0]), .I_CANH_OVERCUR(flt[1]),
        .I_CANL_OVERCUR(flt[2]), .I_AUX_SUPPLY_LOW(flt[3]),
        .I_AUX_SUPPLY_ON(flt[4]), .I_MAIN_REG_OVERCUR(flt[5]),
        .I_DRIVER_REENABLE_CMD(rcmd), .I_FLAG_CLR(fclr),
        .O_DRIVER_EN(drv), .O_XCVR_ON(xon), .O_TXD_DOM_FAIL(fail),
        .O_THERMAL_OVERCURRENT_FLAG(flag));

    function automatic logic [19:0] lfsr(input logic [19:0] s);
        return {s[18:0], s[19] ^ s[16]};
    endfunction
    // Transceiver off on low aux supply, or regulator overload with aux off
    function automatic logic xcvr_exp(input logic [5:0] f);
        return !f[3] && !(f[5] && !f[4]);
    endfunction
    task automatic check(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse_reen();
        @(posedge clk) reen <= 1'b1;
        @(posedge clk) reen <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("Counts: %0d run, %0d bad", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        tick(8);
        for (int i = 0; i < 40; i++) begin
            lf = lfsr(lf);
            @(posedge clk) flt <= (i < 4) ? corner[i] : lf[5:0];
            tick(6);
            fexp = fexp | (|flt[2:0]);
            check(xon, xcvr_exp(flt));
            check(drv, xcvr_exp(flt) && !flt[0]);
            check(flag, fexp);
            @(posedge clk) clr <= 1'b1;
            @(posedge clk) clr <= 1'b0;
            tick(4);
            fexp = |flt[2:0];
            check(flag, fexp);
        end
        $display("test done: random faults");
        @(posedge clk);
        flt  <= 6'h10;
        hold <= 1'b1;
        tick(int'(cfrs_pkg::DOM_TIMEOUT_CYC) - 20);
        check(drv, 1'b1);
        tick(40);
        check(drv, 1'b0);
        check(fail, 1'b1);
        pulse_reen();
        tick(4);
        check(drv, 1'b0);
        @(posedge clk) hold <= 1'b0;
        tick(10);
        check(drv, 1'b0);
        check(fail, 1'b1);
        // Dominant again while waiting: back to tripped, command dropped
        @(posedge clk) hold <= 1'b1;
        tick(8);
        pulse_reen();
        tick(4);
        check(drv, 1'b0);
        @(posedge clk) hold <= 1'b0;
        tick(10);
        check(drv, 1'b0);
        pulse_reen();
        tick(4);
        check(drv, 1'b1);
        check(fail, 1'b0);
        $display("test done: stuck dominant");
        give_verdict();
    end

    // Bound is the stuck-dominant trip time plus 5000 cycles, well above the short random phase
    initial begin
        repeat (int'(cfrs_pkg::DOM_TIMEOUT_CYC) + 5000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
endmodule
